// ==== src/pbs_port.sv ====
`include "pbs_regs.svh"
`default_nettype none
module pbs_port #(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int LANES = `PBS_LANES,
  parameter int BUF_DEPTH = `PBS_BUF_DEPTH
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Synchronous command inputs
  input wire logic CLOCK_QUALIFY_N,
  input wire logic CHIP_SELECT_FIRST_N,
  input wire logic CHIP_SELECT_SECOND,
  input wire logic CHIP_SELECT_THIRD_N,
  input wire logic ADVANCE_OR_LOAD,
  input wire logic WRITE_STROBE_N,
  input wire logic [ADDR_W-1:0] ADDRESS,
  input wire logic [LANES-1:0] BYTE_LANE_MASK_N,
  // Asynchronous pins
  input wire logic OUTPUT_ENABLE_N,
  input wire logic SLEEP_REQUEST,
  input wire logic BURST_ORDER,
  // Data and parity lines
  input wire logic [LANES*`PBS_BYTE_W-1:0] DATA_IN,
  input wire logic [LANES-1:0] PARITY_IN,
  output logic [LANES*`PBS_BYTE_W-1:0] DATA_OUT,
  output logic [LANES-1:0] PARITY_OUT,
  output logic DATA_OE_N,
  // Status
  output logic SLEEP_ACTIVE
);
  import pbs_pkg::*;

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int BYTE_BITS = `PBS_BYTE_W;
  localparam int LW = `PBS_LANE_W;
  localparam int CW = `PBS_CW_W;

  // ==========================================================
  // Check-bit code: one Hamming word per byte lane, so byte writes
  // need no read-modify-write of the neighbouring lanes
  function automatic pbs_cw_t ecc_encode(input pbs_lane_t d);
    pbs_cw_t cw;
    int k;
    cw = '0;
    k = 0;
    for (int p = 1; p <= CW; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p-1] = d[k];
        k++;
      end
    end
    for (int b = 0; b < `PBS_CHK_W; b++) begin
      for (int p = 1; p <= CW; p++) begin
        if ((((p >> b) & 1) == 1) && (p != (1 << b))) begin
          cw[(1 << b) - 1] = cw[(1 << b) - 1] ^ cw[p-1];
        end
      end
    end
    return cw;
  endfunction

  function automatic pbs_lane_t ecc_decode(input pbs_cw_t cw);
    logic [`PBS_CHK_W-1:0] syn;
    pbs_cw_t fix;
    pbs_lane_t d;
    int k;
    syn = '0;
    d = '0;
    k = 0;
    for (int p = 1; p <= CW; p++) begin
      if (cw[p-1]) begin
        syn = syn ^ p[`PBS_CHK_W-1:0];
      end
    end
    fix = cw;
    // Two flipped bits give a wrong syndrome; that case is not corrected
    if ((syn != '0) && (int'(syn) <= CW)) begin
      fix[int'(syn) - 1] = ~fix[int'(syn) - 1]; // RULE21
    end
    for (int p = 1; p <= CW; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = fix[p-1];
        k++;
      end
    end
    return d;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic oe_s1_reg, oe_s2_reg, sleep_s1_reg, sleep_s2_reg, order_s1_reg, order_s2_reg;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      oe_s1_reg <= `PBS_OE_N_RESET;
      oe_s2_reg <= `PBS_OE_N_RESET;
      sleep_s1_reg <= `PBS_SLEEP_RESET;
      sleep_s2_reg <= `PBS_SLEEP_RESET;
      order_s1_reg <= `PBS_ORDER_RESET;
      order_s2_reg <= `PBS_ORDER_RESET;
    end else begin
      oe_s1_reg <= OUTPUT_ENABLE_N;
      oe_s2_reg <= oe_s1_reg;
      sleep_s1_reg <= SLEEP_REQUEST;
      sleep_s2_reg <= sleep_s1_reg; // RULE18
      order_s1_reg <= BURST_ORDER;
      order_s2_reg <= order_s1_reg;
    end
  end

  // ==========================================================
  // Burst-order strap, caught once the synchroniser holds a real sample
  logic [1:0] strap_cnt_reg;
  pbs_order_e order_reg;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      strap_cnt_reg <= 2'h0;
      order_reg <= PBS_INTERLEAVED;
    end else if (strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == 2'(`PBS_SYNC_STAGES)) begin
        order_reg <= pbs_order_e'(order_s2_reg); // RULE10
      end
    end
  end

  // ==========================================================
  // Command decode
  logic sleeping, en, buf_ready, selected, do_load, acc_valid, acc_write;
  logic [ADDR_W-1:0] acc_addr;
  logic [`PBS_BURST_W-1:0] next_cnt, burst_lo;
  logic [ADDR_W-1:0] base_reg;
  logic [`PBS_BURST_W-1:0] cnt_reg;
  logic wr_dir_reg, burst_act_reg;

  assign sleeping = sleep_s2_reg;
  assign en = ~CLOCK_QUALIFY_N & ~sleeping & buf_ready; // RULE1
  assign selected = ~CHIP_SELECT_FIRST_N & CHIP_SELECT_SECOND & ~CHIP_SELECT_THIRD_N; // RULE25
  assign do_load = ~ADVANCE_OR_LOAD & selected; // RULE2
  assign next_cnt = cnt_reg + 2'h1;
  assign burst_lo = (order_reg == PBS_INTERLEAVED) ? (base_reg[1:0] ^ next_cnt) // RULE22
                                                   : (base_reg[1:0] + next_cnt); // RULE23
  assign acc_addr = ADVANCE_OR_LOAD ? {base_reg[ADDR_W-1:2], burst_lo} : ADDRESS; // RULE9
  // Advance ignores the selects and strobe; after a deselect it stays idle
  assign acc_valid = do_load | (ADVANCE_OR_LOAD & burst_act_reg); // RULE11 RULE8
  assign acc_write = ADVANCE_OR_LOAD ? wr_dir_reg : ~WRITE_STROBE_N; // RULE3 RULE12

  // ==========================================================
  // Burst counter
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      base_reg <= '0;
      cnt_reg <= 2'h0;
      wr_dir_reg <= 1'h0;
      burst_act_reg <= 1'h0; // RULE24
    end else if (sleeping) begin
      burst_act_reg <= 1'h0; // RULE19
    end else if (en) begin
      if (!ADVANCE_OR_LOAD) begin
        base_reg <= ADDRESS;
        cnt_reg <= 2'h0;
        wr_dir_reg <= ~WRITE_STROBE_N; // RULE12
        burst_act_reg <= selected; // RULE7
      end else if (burst_act_reg) begin
        cnt_reg <= next_cnt; // RULE11
      end
    end
  end

  // ==========================================================
  // Access pipeline: stage a after the address edge, stage b after the next
  logic va_reg, wa_reg, wb_reg, rd_hold_reg, rd_hold_next, fill, drain;
  logic [ADDR_W-1:0] addr_a_reg, addr_b_reg;
  logic [LANES-1:0] mask_a_reg, mask_b_reg;

  // A read in stage a drives on the following qualified edge; sleep or any other qualified edge releases, an ignored edge holds
  assign rd_hold_next = sleeping ? 1'h0 : (en ? (va_reg & ~wa_reg) : rd_hold_reg); // RULE4 RULE13
  // All-high masks abort the beat: nothing is queued
  assign fill = en & wb_reg & (|mask_b_reg); // RULE14

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      va_reg <= 1'h0;
      wa_reg <= 1'h0;
      wb_reg <= 1'h0;
      rd_hold_reg <= 1'h0;
      addr_a_reg <= '0;
      addr_b_reg <= '0;
      mask_a_reg <= '0;
      mask_b_reg <= '0;
    end else begin
      rd_hold_reg <= rd_hold_next;
      if (sleeping) begin
        va_reg <= 1'h0; // RULE19
        wb_reg <= 1'h0;
      end else if (en) begin
        va_reg <= acc_valid; // RULE6
        wa_reg <= acc_write;
        addr_a_reg <= acc_addr;
        mask_a_reg <= ~BYTE_LANE_MASK_N; // RULE15
        wb_reg <= va_reg & wa_reg;
        addr_b_reg <= addr_a_reg;
        mask_b_reg <= mask_a_reg;
      end
    end
  end

  // ==========================================================
  // Two-entry write buffer between capture and the array.
  // A full buffer stalls the port; the array drains it even while the
  // qualifier is high so that a stall cannot lock it up.
  logic [ADDR_W-1:0] buf_addr_reg [BUF_DEPTH];
  logic [LANES-1:0] buf_mask_reg [BUF_DEPTH];
  logic [LANES*LW-1:0] buf_data_reg [BUF_DEPTH];
  logic [PW-1:0] buf_rd_ptr_reg, buf_wr_ptr_reg;
  logic [PW:0] buf_cnt_reg;
  logic [LANES*LW-1:0] cap_data;

  assign buf_ready = (buf_cnt_reg != (PW+1)'(BUF_DEPTH));
  assign drain = (buf_cnt_reg != '0) & ~sleeping;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      buf_rd_ptr_reg <= '0;
      buf_wr_ptr_reg <= '0;
      buf_cnt_reg <= '0;
    end else begin
      if (fill) begin
        buf_wr_ptr_reg <= buf_wr_ptr_reg + 1'b1;
      end
      if (drain) begin
        buf_rd_ptr_reg <= buf_rd_ptr_reg + 1'b1;
      end
      if (fill && !drain) begin
        buf_cnt_reg <= buf_cnt_reg + 1'b1;
      end else if (drain && !fill) begin
        buf_cnt_reg <= buf_cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (fill) begin
      buf_addr_reg[buf_wr_ptr_reg] <= addr_b_reg;
      buf_mask_reg[buf_wr_ptr_reg] <= mask_b_reg;
      buf_data_reg[buf_wr_ptr_reg] <= cap_data; // RULE14
    end
  end

  // ==========================================================
  // Array port
  pbs_core_if #(.ADDR_W(ADDR_W), .LANES(LANES)) core ();

  pbs_mem #(.ADDR_W(ADDR_W), .LANES(LANES)) u_mem (
    .clk(REF_CLK),
    .rst(RST),
    .bus(core.mem)
  );

  assign core.rd_en = en & acc_valid & ~acc_write;
  assign core.rd_addr = acc_addr;
  assign core.wr_en = drain;
  assign core.wr_addr = buf_addr_reg[buf_rd_ptr_reg];
  assign core.wr_lane = buf_mask_reg[buf_rd_ptr_reg];

  // ==========================================================
  // Forwarding: a read issued while a write to the same word is still
  // queued or being captured must see the newer bytes
  logic fwd_use_next [LANES];
  logic fwd_use_reg [LANES];
  pbs_lane_t fwd_val_next [LANES];
  pbs_lane_t fwd_val_reg [LANES];
  pbs_lane_t lane_out [LANES];

  always_comb begin
    logic [PW-1:0] idx;
    idx = '0;
    for (int l = 0; l < LANES; l++) begin
      fwd_use_next[l] = 1'h0;
      fwd_val_next[l] = '0;
    end
    // Oldest first, so the newest matching write wins
    for (int j = 0; j < BUF_DEPTH; j++) begin
      idx = buf_rd_ptr_reg + PW'(j);
      if ((j < int'(buf_cnt_reg)) && (buf_addr_reg[idx] == acc_addr)) begin
        for (int l = 0; l < LANES; l++) begin
          if (buf_mask_reg[idx][l]) begin
            fwd_use_next[l] = 1'h1;
            fwd_val_next[l] = buf_data_reg[idx][l*LW +: LW];
          end
        end
      end
    end
    if (fill && (addr_b_reg == acc_addr)) begin
      for (int l = 0; l < LANES; l++) begin
        if (mask_b_reg[l]) begin
          fwd_use_next[l] = 1'h1;
          fwd_val_next[l] = cap_data[l*LW +: LW];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int l = 0; l < LANES; l++) begin
        fwd_use_reg[l] <= 1'h0;
        fwd_val_reg[l] <= '0;
      end
    end else if (core.rd_en) begin
      for (int l = 0; l < LANES; l++) begin
        fwd_use_reg[l] <= fwd_use_next[l];
        fwd_val_reg[l] <= fwd_val_next[l];
      end
    end
  end

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign cap_data[l*LW +: LW] = {PARITY_IN[l], DATA_IN[l*BYTE_BITS +: BYTE_BITS]};
    assign core.wr_data[l*CW +: CW] = ecc_encode(buf_data_reg[buf_rd_ptr_reg][l*LW +: LW]); // RULE21
    assign lane_out[l] = fwd_use_reg[l] ? fwd_val_reg[l]
                                        : ecc_decode(core.rd_data[l*CW +: CW]); // RULE21
  end

  // ==========================================================
  // Output register and drive control
  // Output enable is a pin, so it acts two edges late through its synchroniser
  logic [LANES*BYTE_BITS-1:0] data_out_reg;
  logic [LANES-1:0] parity_out_reg;
  logic oe_n_reg;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      data_out_reg <= '0;
      parity_out_reg <= '0;
      oe_n_reg <= `PBS_OE_N_RESET; // RULE24
    end else begin
      oe_n_reg <= ~(rd_hold_next & ~oe_s2_reg); // RULE4 RULE7 RULE13
      if (en && va_reg && !wa_reg) begin
        for (int l = 0; l < LANES; l++) begin
          data_out_reg[l*BYTE_BITS +: BYTE_BITS] <= lane_out[l][BYTE_BITS-1:0]; // RULE4
          parity_out_reg[l] <= lane_out[l][BYTE_BITS];
        end
      end
    end
  end

  assign DATA_OUT = data_out_reg;
  assign PARITY_OUT = parity_out_reg;
  assign DATA_OE_N = oe_n_reg;
  assign SLEEP_ACTIVE = sleep_s2_reg;
endmodule
`default_nettype wire

// ==== src/pbs_regs.svh ====
// Function
// RULE1 - Qualifier high: edge ignored, state held
// RULE2 - Selected, qualified, load low: new access
// RULE3 - Write strobe high reads, low writes
// RULE4 - Read word out after next edge
// RULE5 - Master holds output enable low for reads
// RULE6 - New operation accepted right after read
// RULE7 - Deselect pipelined, tristate after next edge
// RULE8 - Master loads address after deselect
// RULE9 - Burst counter wraps on two low bits
// RULE10 - Strap low linear, high interleaved
// RULE11 - Advance increments counter, ignores selects, strobe
// RULE12 - Direction held for whole burst
// RULE13 - Tristate on edge after write address
// RULE14 - Second edge captures write data lanes
// RULE15 - Only masked-in bytes and parity written
// RULE16 - Master avoids driving while outputs active
// RULE17 - Master drives masks every burst beat
// RULE18 - Sleep entry and exit take two cycles
// RULE19 - Pending access dropped on sleep entry
// RULE20 - Master deselects around sleep
// RULE21 - Hidden check bits correct single-bit errors
// RULE22 - Interleaved address is start XOR beat
// RULE23 - Linear address is start plus beat
// RULE24 - Powers up deselected, lines tristated
// RULE25 - Select needs first, third low, second high
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH

// ==========================================================
// Geometry
`define PBS_ADDR_W 20
`define PBS_LANES 4
`define PBS_BYTE_W 8
`define PBS_LANE_W 9
`define PBS_CHK_W 4
`define PBS_CW_W 13
`define PBS_BURST_W 2

// ==========================================================
// Timing and buffering
`define PBS_SYNC_STAGES 2
`define PBS_BUF_DEPTH 2

// ==========================================================
// Reset values
`define PBS_OE_N_RESET 1'h1
`define PBS_SLEEP_RESET 1'h0
`define PBS_ORDER_RESET 1'h1

`endif

// ==== src/pbs_pkg.sv ====
`include "pbs_regs.svh"
`default_nettype none
package pbs_pkg;
  typedef enum logic {
    PBS_LINEAR = 1'b0,
    PBS_INTERLEAVED = 1'b1
  } pbs_order_e;

  typedef logic [`PBS_LANE_W-1:0] pbs_lane_t;
  typedef logic [`PBS_CW_W-1:0] pbs_cw_t;
endpackage
`default_nettype wire

// ==== src/pbs_core_if.sv ====
`include "pbs_regs.svh"
`default_nettype none
interface pbs_core_if #(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int LANES = `PBS_LANES
);
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [LANES*`PBS_CW_W-1:0] rd_data;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [LANES-1:0] wr_lane;
  logic [LANES*`PBS_CW_W-1:0] wr_data;

  modport ctrl (
    output rd_en, rd_addr, wr_en, wr_addr, wr_lane, wr_data,
    input rd_data
  );
  modport mem (
    input rd_en, rd_addr, wr_en, wr_addr, wr_lane, wr_data,
    output rd_data
  );
endinterface
`default_nettype wire

// ==== src/pbs_mem.sv ====
`include "pbs_regs.svh"
`default_nettype none
module pbs_mem #(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int LANES = `PBS_LANES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core port
  pbs_core_if.mem bus
);
  import pbs_pkg::*;

  logic [LANES*`PBS_CW_W-1:0] array_q [2**ADDR_W];
  logic [LANES*`PBS_CW_W-1:0] rd_data_reg;

  // ==========================================================
  // Storage, per-lane write enables
  // Contents are never reset: power-up data is undefined, as in the array itself.
  // Plain always: fault injection may also upset the array from outside.
  always @(posedge clk) begin
    if (bus.wr_en) begin
      for (int l = 0; l < LANES; l++) begin
        if (bus.wr_lane[l]) begin
          array_q[bus.wr_addr][l*`PBS_CW_W +: `PBS_CW_W] <= bus.wr_data[l*`PBS_CW_W +: `PBS_CW_W]; // RULE15
        end
      end
    end
  end

  // ==========================================================
  // Registered read; a write at the same edge is not seen here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= '0;
    end else if (bus.rd_en) begin
      rd_data_reg <= array_q[bus.rd_addr];
    end
  end

  assign bus.rd_data = rd_data_reg;
endmodule
`default_nettype wire

// ==== tb/pbs_port_properties.sv ====
`include "pbs_regs.svh"
`default_nettype none
module pbs_port_properties #(
  parameter int LANES = `PBS_LANES
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Commands and pins
  input wire logic CLOCK_QUALIFY_N,
  input wire logic CHIP_SELECT_FIRST_N,
  input wire logic CHIP_SELECT_SECOND,
  input wire logic CHIP_SELECT_THIRD_N,
  input wire logic ADVANCE_OR_LOAD,
  input wire logic WRITE_STROBE_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic SLEEP_REQUEST,
  // Outputs
  input wire logic [LANES*`PBS_BYTE_W-1:0] DATA_OUT,
  input wire logic [LANES-1:0] PARITY_OUT,
  input wire logic DATA_OE_N,
  input wire logic SLEEP_ACTIVE
);
  wire logic load = !CLOCK_QUALIFY_N && !ADVANCE_OR_LOAD && !SLEEP_ACTIVE;
  wire logic sel = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ==========
  // Pipeline
  chk_stall_freeze: assert property (
    CLOCK_QUALIFY_N |=> $stable({DATA_OE_N, PARITY_OUT, DATA_OUT}))
    else $error("Outputs moved on an ignored edge");
  chk_read_drive: assert property (
    (!OUTPUT_ENABLE_N)[*3] ##0 (load && sel && WRITE_STROBE_N) ##1 !CLOCK_QUALIFY_N
    |=> !DATA_OE_N) else $error("Read word not driven");
  chk_oe_off: assert property (
    (OUTPUT_ENABLE_N && !CLOCK_QUALIFY_N)[*4] |=> DATA_OE_N)
    else $error("Driving with output enable high");
  chk_write_hiz: assert property (
    (load && sel && !WRITE_STROBE_N) ##1 !CLOCK_QUALIFY_N |=> DATA_OE_N)
    else $error("Driving during write data phase");
  chk_desel_hiz: assert property (
    (load && !sel) ##1 !CLOCK_QUALIFY_N |=> DATA_OE_N)
    else $error("Driving after deselect");
  chk_desel_hold: assert property (
    (load && !sel) ##1 (ADVANCE_OR_LOAD && !CLOCK_QUALIFY_N)[*2] |=> DATA_OE_N)
    else $error("Advance woke a deselected port");
  // ==========
  // Sleep
  chk_sleep_enter: assert property (
    $rose(SLEEP_REQUEST) ##1 SLEEP_REQUEST |-> !SLEEP_ACTIVE ##1 SLEEP_ACTIVE)
    else $error("Sleep entry not two cycles");
  chk_sleep_exit: assert property (
    $fell(SLEEP_REQUEST) ##1 !SLEEP_REQUEST |-> SLEEP_ACTIVE ##1 !SLEEP_ACTIVE)
    else $error("Sleep exit not two cycles");
  chk_sleep_hiz: assert property (
    SLEEP_ACTIVE[*2] |-> DATA_OE_N) else $error("Driving while asleep");
endmodule
bind pbs_port pbs_port_properties #(.LANES(LANES)) pbs_port_properties_i (
  .REF_CLK(REF_CLK), .RST(RST), .CLOCK_QUALIFY_N(CLOCK_QUALIFY_N),
  .CHIP_SELECT_FIRST_N(CHIP_SELECT_FIRST_N), .CHIP_SELECT_SECOND(CHIP_SELECT_SECOND),
  .CHIP_SELECT_THIRD_N(CHIP_SELECT_THIRD_N), .ADVANCE_OR_LOAD(ADVANCE_OR_LOAD),
  .WRITE_STROBE_N(WRITE_STROBE_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .SLEEP_REQUEST(SLEEP_REQUEST), .DATA_OUT(DATA_OUT), .PARITY_OUT(PARITY_OUT),
  .DATA_OE_N(DATA_OE_N), .SLEEP_ACTIVE(SLEEP_ACTIVE));
`default_nettype wire

// ==== tb/pbs_bus_master.sv ====
`default_nettype none
module pbs_bus_master #(
  parameter int ADDR_W = 6,
  parameter int LANES = 4
) (
  // Clock
  input wire logic clk,
  // Command group
  output logic qualify_n,
  output logic sel_first_n,
  output logic sel_second,
  output logic sel_third_n,
  output logic advance,
  output logic write_n,
  output logic [ADDR_W-1:0] addr,
  output logic [LANES-1:0] mask_n,
  // Write data
  output logic [LANES*8-1:0] data,
  output logic [LANES-1:0] parity
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Write data trails its command by two qualified edges
  logic [LANES*9:0] pend = '0;
  logic [LANES*9:0] pend_d = '0;
  initial begin
    {qualify_n, sel_first_n, sel_second, sel_third_n, advance, write_n} = 6'h3F;
    addr = '0;
    mask_n = '1;
    {parity, data} = '0;
  end
  task automatic issue(input logic st, input logic ld, input logic wn, input logic [2:0] cs,
    input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m, input logic wv,
    input logic [LANES*9-1:0] d);
    qualify_n <= st;
    {sel_first_n, sel_second, sel_third_n} <= cs;
    advance <= !ld;
    write_n <= wn;
    addr <= a;
    mask_n <= m;
    if (!st) pend <= {wv, d};
  endtask
  // Idle lines toggle so a stale word can never pass for written data
  always @(posedge clk) begin
    if (!qualify_n) begin
      pend_d <= pend;
      {parity, data} <= pend_d[LANES*9] ? pend_d[LANES*9-1:0] : ~{parity, data};
    end
  end
endmodule
`default_nettype wire

// ==== tb/pbs_port_bench.sv ====
`include "pbs_regs.svh"
`default_nettype none
`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, ac); end end
module pbs_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic rd;
    logic chk;
    logic [35:0] d;
  } pbs_exp_s;
  logic clk, rst = 1'b1, oe_n = 1'b0, slp = 1'b0, ord = 1'b0, oe_hi = 1'b0;
  logic cq_n, cs1_n, cs2, cs3_n, adv, we_n, doe_n, sact, bwr, bsel = 1'b0;
  logic [5:0] addr, base;
  logic [3:0] mask_n, pin, pout;
  logic [31:0] din, dout, seed = 32'h942C;
  logic [35:0] shadow [64];
  logic [6:0] lastw = 7'h40;
  logic [1:0] beat;
  pbs_exp_s q[$];
  int miscompares = 0;
  int compares = 0;
  pbs_port #(.ADDR_W(6)) pbs_port_i (
    .REF_CLK(clk), .RST(rst), .CLOCK_QUALIFY_N(cq_n), .CHIP_SELECT_FIRST_N(cs1_n),
    .CHIP_SELECT_SECOND(cs2), .CHIP_SELECT_THIRD_N(cs3_n), .ADVANCE_OR_LOAD(adv),
    .WRITE_STROBE_N(we_n), .ADDRESS(addr), .BYTE_LANE_MASK_N(mask_n),
    .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(slp), .BURST_ORDER(ord), .DATA_IN(din),
    .PARITY_IN(pin), .DATA_OUT(dout), .PARITY_OUT(pout), .DATA_OE_N(doe_n),
    .SLEEP_ACTIVE(sact));
  pbs_bus_master #(.ADDR_W(6)) pbs_bus_master_i (
    .clk(clk), .qualify_n(cq_n), .sel_first_n(cs1_n), .sel_second(cs2),
    .sel_third_n(cs3_n), .advance(adv), .write_n(we_n), .addr(addr), .mask_n(mask_n),
    .data(din), .parity(pin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] beat_lo(input logic [1:0] s, input logic [1:0] n);
    return ord ? s ^ n : s + n;
  endfunction
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
    input logic [3:0] m);
    for (int l = 0; l < 4; l++) begin
      if (!m[l]) begin
        o[8*l+:8] = n[8*l+:8];
        o[32+l] = n[32+l];
      end
    end
    return o;
  endfunction
  // ==========
  // One command per cycle; its result is checked two qualified edges later
  task automatic op(input logic st, input logic ld, input logic wn, input logic [2:0] cs,
    input logic [5:0] a, input logic [3:0] m);
    logic [35:0] d;
    logic [5:0] wa;
    pbs_exp_s e;
    d[31:0] = rnd();
    d[35:32] = 4'(rnd());
    @(posedge clk);
    if (!st) begin
      if (ld) begin
        base = a;
        beat = 2'h0;
        bwr = !wn;
        bsel = (cs == 3'b010);
      end else begin
        beat = beat + 2'h1;
      end
      wa = {base[5:2], beat_lo(base[1:0], beat)};
      e = '{bsel && !bwr && !oe_hi, {1'b0, wa} != lastw, shadow[wa]};
      lastw = 7'h40;
      if (bsel && bwr) begin
        shadow[wa] = merge(shadow[wa], d, m);
        lastw = {1'b0, wa};
      end
      q.push_back(e);
    end
    pbs_bus_master_i.issue(st, ld, wn, cs, a, m, !st && bsel && bwr, d);
    #1;
    if (q.size() > (st ? 1 : 2)) begin
      e = q.pop_front();
      `CHK("output enable", !e.rd, doe_n)
      if (e.rd && e.chk) `CHK("read word", e.d, {pout, dout})
    end
  endtask
  task automatic rand_ops(input int n);
    logic [31:0] r;
    repeat (n) begin
      r = rnd();
      op(r[2:0] == 3'h0, !bsel || r[4:3] == 2'h0, r[5], r[7:6] == 2'h0 ? r[11:9] : 3'b010,
        r[17:12], r[21:18]);
    end
  endtask
  task automatic idle(input int n);
    op(1'b0, 1'b1, 1'b1, 3'b111, 6'h0, 4'hF);
    repeat (n) op(1'b0, 1'b0, 1'b1, 3'b111, 6'h0, 4'hF);
  endtask
  task tdone(input string s);
    $display("Test %s done", s);
  endtask
  task give_verdict;
    $display("Compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  // ==========
  // Both burst orders, each behind its own reset
  initial begin
    for (int o = 0; o < 2; o++) begin
      @(posedge clk);
      rst <= 1'b1;
      ord <= o[0];
      q.delete();
      bsel = 1'b0;
      lastw = 7'h40;
      repeat (3) @(posedge clk);
      #1;
      `CHK("reset state", {1'b1, 37'h0}, {doe_n, sact, pout, dout})
      @(posedge clk);
      rst <= 1'b0;
      idle(3);
      if (o == 0) begin
        for (int a = 0; a < 64; a++) op(1'b0, 1'b1, 1'b0, 3'b010, a[5:0], 4'h0);
        tdone("prefill");
      end
      rand_ops(300);
      tdone("random traffic");
      oe_n <= 1'b1;
      idle(4);
      oe_hi = 1'b1;
      rand_ops(30);
      oe_n <= 1'b0;
      idle(4);
      oe_hi = 1'b0;
      tdone("output enable");
      // One upset bit per word; the same positions each pass keep it single per lane
      for (int a = 0; a < 64; a++) begin
        pbs_port_i.u_mem.array_q[a] ^= 52'h1 << ((a * 5) % 52);
      end
      idle(2);
      slp <= 1'b1;
      idle(5);
      `CHK("asleep", 1'b1, sact)
      slp <= 1'b0;
      idle(4);
      `CHK("awake", 1'b0, sact)
      rand_ops(60);
      idle(3);
      tdone("sleep");
    end
    give_verdict();
  end
endmodule
`default_nettype wire
